/* include/pp_branch_params.svh */
`ifndef PP_BRANCH_PARAMS_SVH
`define PP_BRANCH_PARAMS_SVH

// ----------------------------------------------------------------
// Opcodes handled by this unit
// ----------------------------------------------------------------
`define OP_BRANCH_BASE_REL_SAVE 8'h12
`define OP_BRANCH_ROM_SAVE 8'h46
`define OP_BRANCH_ABSOLUTE_SAVE 8'h52
`define OP_BRANCH_PC_RELATIVE_A 8'h5A
`define OP_BRANCH_PC_RELATIVE_B 8'h5E
`define OP_BRANCH_ROM 8'h42
`define OP_BRANCH_BASE_RELATIVE_A 8'h02
`define OP_BRANCH_BASE_RELATIVE_B 8'h32
`define OP_BRANCH_ABSOLUTE_A 8'h4A
`define OP_BRANCH_ABSOLUTE_B 8'h4E
`define OP_BRANCH_ROM_STORE_SLOT 8'h56
`define OP_SET_PROC_FLAG 8'h86
`define OP_CLEAR_PROC_FLAG 8'h82
`define OP_TEST_PROC_FLAG_ONE 8'h8E
`define OP_TEST_PROC_FLAG_ZERO 8'h8A

// ----------------------------------------------------------------
// Addresses, increments and reset values
// ----------------------------------------------------------------
`define SLOT_BASE_ADDR 16'h0020
`define PC_STEP_NEXT 16'h0001
`define PC_STEP_SKIP 16'h0002
`define FETCH_ROM_RESET 1'b1

`endif

/* include/pp_branch_pkg.sv */
package pp_branch_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STATE_IDLE = 2'b01,
    STATE_CR_WAIT = 2'b10
  } state_t;

  typedef enum logic [1:0] {
    TARGET_PC_REL = 2'h0,
    TARGET_BASE_REL = 2'h1,
    TARGET_ABSOLUTE = 2'h2,
    TARGET_ROM = 2'h3
  } target_t;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_BRANCH = 3'h1,
    KIND_FLAG_SET = 3'h2,
    KIND_FLAG_CLEAR = 3'h3,
    KIND_TEST_ONE = 3'h4,
    KIND_TEST_ZERO = 3'h5
  } kind_t;

  typedef struct packed {
    kind_t kind;
    target_t target;
    logic save_reg;
    logic save_slot;
  } decode_t;

endpackage

/* include/flag_op_if.sv */
`timescale 1ns/10ps

// Carries one communication-register byte through the flag bit logic
interface flag_op_if #(parameter int VP_W = 3);
  logic [(1 << VP_W)-1:0] byte_in;
  logic [(1 << VP_W)-1:0] byte_out;
  logic [VP_W-1:0] vp;
  logic set_bit;
  logic clear_bit;
  logic bit_value;

  modport alu (input byte_in, vp, set_bit, clear_bit, output byte_out, bit_value);
  modport user (output byte_in, vp, set_bit, clear_bit, input byte_out, bit_value);
endinterface

/* logic/flag_bit_alu.sv */
`timescale 1ns/10ps

// Picks the executing processor's bit out of a byte and modifies only it
module flag_bit_alu (
  flag_op_if.alu fop
);
  // ----------------------------------------------------------------
  // Bit select and modify
  // ----------------------------------------------------------------
  always_comb begin
    fop.bit_value = fop.byte_in[fop.vp];  // see RQ12
    fop.byte_out = fop.byte_in;
    if (fop.set_bit) begin
      fop.byte_out[fop.vp] = 1'b1;  // see RQ10
    end else if (fop.clear_bit) begin
      fop.byte_out[fop.vp] = 1'b0;  // see RQ11
    end
  end
endmodule

/* logic/pp_branch_and_flag_unit.sv */
`timescale 1ns/10ps
`include "pp_branch_params.svh"

// Summary of operation
// (RQ1) Save-return branches write PC plus one to the selected work register, then branch.
// (RQ2) Saved register MSB is 1 when fetching from central memory, 0 from ROM.
// (RQ3) Opcode 12 targets base-relative memory, 46 ROM, 52 absolute memory.
// (RQ4) Opcodes 5A and 5E branch PC-relative, 42 to ROM, nothing saved.
// (RQ5) Opcodes 02, 32 branch base-relative; 4A, 4E absolute; nothing saved.
// (RQ6) Opcode 56 stores PC plus one in a per-processor memory slot, branches to ROM.
// (RQ7) The eight slots are consecutive from address hex 20, indexed by processor number.
// (RQ8) Slot word MSB is 1 for central-memory fetch, 0 for ROM fetch.
// (RQ9) Programs must not use indirect addressing with slot store or flag instructions.
// (RQ10) Opcode 86 sets the executing processor's flag bit in the addressed byte.
// (RQ11) Opcode 82 clears the executing processor's flag bit in the addressed byte.
// (RQ12) Flag bit position comes from the executing processor's number.
// (RQ13) Opcode 8E skips the next instruction when the flag bit is one.
// (RQ14) Opcode 8A skips the next instruction when the flag bit is zero.
// (RQ15) Unmet flag test advances PC by one, flag left unchanged.
module pp_branch_and_flag_unit import pp_branch_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 32,
  parameter int VP_W = 3,
  parameter int CR_ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [3:0] r_field,
  input wire logic [ADDR_W-1:0] tn_field,
  input wire logic indirect,
  input wire logic [VP_W-1:0] vp_num,
  input wire logic [ADDR_W-1:0] pc_in,
  input wire logic [ADDR_W-1:0] base_in,
  output logic instr_ready_q,
  output logic instr_reject_q,
  // Program counter update
  output logic pc_load_q,
  output logic [ADDR_W-1:0] pc_value_q,
  output logic fetch_rom_q,
  // Work register write
  output logic vpr_we_q,
  output logic [3:0] vpr_idx_q,
  output logic [DATA_W-1:0] vpr_data_q,
  // Central memory write
  output logic cm_we_q,
  output logic [ADDR_W-1:0] cm_addr_q,
  output logic [DATA_W-1:0] cm_data_q,
  // Communication register byte access
  output logic cr_rd_req_q,
  output logic [CR_ADDR_W-1:0] cr_addr_q,
  input wire logic cr_rd_valid,
  input wire logic [(1 << VP_W)-1:0] cr_rd_data,
  output logic cr_we_q,
  output logic [(1 << VP_W)-1:0] cr_wdata_q
);
  localparam int BYTE_W = 1 << VP_W;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Two stages so that release never lands near a clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Decode and return-word helpers
  // ----------------------------------------------------------------
  function automatic decode_t decode_op(input logic [7:0] op);
    decode_t d;
    d = '{kind: KIND_NONE, target: TARGET_PC_REL, save_reg: 1'b0, save_slot: 1'b0};
    unique case (op)
      `OP_BRANCH_BASE_REL_SAVE: d = '{KIND_BRANCH, TARGET_BASE_REL, 1'b1, 1'b0};  // see RQ3
      `OP_BRANCH_ROM_SAVE: d = '{KIND_BRANCH, TARGET_ROM, 1'b1, 1'b0};  // see RQ3
      `OP_BRANCH_ABSOLUTE_SAVE: d = '{KIND_BRANCH, TARGET_ABSOLUTE, 1'b1, 1'b0};  // see RQ3
      `OP_BRANCH_PC_RELATIVE_A, `OP_BRANCH_PC_RELATIVE_B: begin
        d = '{KIND_BRANCH, TARGET_PC_REL, 1'b0, 1'b0};  // see RQ4
      end
      `OP_BRANCH_ROM: d = '{KIND_BRANCH, TARGET_ROM, 1'b0, 1'b0};  // see RQ4
      `OP_BRANCH_BASE_RELATIVE_A, `OP_BRANCH_BASE_RELATIVE_B: begin
        d = '{KIND_BRANCH, TARGET_BASE_REL, 1'b0, 1'b0};  // see RQ5
      end
      `OP_BRANCH_ABSOLUTE_A, `OP_BRANCH_ABSOLUTE_B: begin
        d = '{KIND_BRANCH, TARGET_ABSOLUTE, 1'b0, 1'b0};  // see RQ5
      end
      `OP_BRANCH_ROM_STORE_SLOT: d = '{KIND_BRANCH, TARGET_ROM, 1'b0, 1'b1};  // see RQ6
      `OP_SET_PROC_FLAG: d.kind = KIND_FLAG_SET;
      `OP_CLEAR_PROC_FLAG: d.kind = KIND_FLAG_CLEAR;
      `OP_TEST_PROC_FLAG_ONE: d.kind = KIND_TEST_ONE;
      `OP_TEST_PROC_FLAG_ZERO: d.kind = KIND_TEST_ZERO;
      default: d.kind = KIND_NONE;
    endcase
    return d;
  endfunction

  // Return word: PC plus one low, MSB marks central-memory fetch
  function automatic logic [DATA_W-1:0] return_word(input logic rom, input logic [ADDR_W-1:0] pc);
    logic [DATA_W-1:0] w;
    w = '0;
    w[ADDR_W-1:0] = pc + ADDR_W'(`PC_STEP_NEXT);
    w[DATA_W-1] = ~rom;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Issue decode and effective address
  // ----------------------------------------------------------------
  decode_t dec;
  logic take;
  logic [ADDR_W-1:0] target_addr;

  // The indirect flag is not consulted: its outcome is left undefined
  always_comb begin
    dec = decode_op(opcode);
    take = instr_valid && instr_ready_q;
    unique case (dec.target)
      TARGET_PC_REL: target_addr = pc_in + tn_field;  // see RQ4
      TARGET_BASE_REL: target_addr = base_in + tn_field;  // see RQ5
      TARGET_ABSOLUTE: target_addr = tn_field;  // see RQ5
      TARGET_ROM: target_addr = tn_field;  // see RQ3
    endcase
  end

  // ----------------------------------------------------------------
  // Flag bit logic
  // ----------------------------------------------------------------
  flag_op_if #(.VP_W(VP_W)) fop ();
  state_t state_q;
  state_t state_d;
  kind_t kind_q;
  kind_t kind_d;
  logic [VP_W-1:0] vp_q;
  logic [VP_W-1:0] vp_d;
  logic [ADDR_W-1:0] pc_hold_q;
  logic [ADDR_W-1:0] pc_hold_d;

  always_comb begin
    fop.byte_in = cr_rd_data;
    fop.vp = vp_q;  // see RQ12
    fop.set_bit = (kind_q == KIND_FLAG_SET);
    fop.clear_bit = (kind_q == KIND_FLAG_CLEAR);
  end

  flag_bit_alu u_flag_bit_alu (
    .fop(fop)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic instr_ready_d;
  logic instr_reject_d;
  logic pc_load_d;
  logic [ADDR_W-1:0] pc_value_d;
  logic fetch_rom_d;
  logic vpr_we_d;
  logic [3:0] vpr_idx_d;
  logic [DATA_W-1:0] vpr_data_d;
  logic cm_we_d;
  logic [ADDR_W-1:0] cm_addr_d;
  logic [DATA_W-1:0] cm_data_d;
  logic cr_rd_req_d;
  logic [CR_ADDR_W-1:0] cr_addr_d;
  logic cr_we_d;
  logic [BYTE_W-1:0] cr_wdata_d;
  logic skip;

  // Strobes default low so each lasts exactly one cycle
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    vp_d = vp_q;
    pc_hold_d = pc_hold_q;
    instr_reject_d = 1'b0;
    pc_load_d = 1'b0;
    pc_value_d = pc_value_q;
    fetch_rom_d = fetch_rom_q;
    vpr_we_d = 1'b0;
    vpr_idx_d = vpr_idx_q;
    vpr_data_d = vpr_data_q;
    cm_we_d = 1'b0;
    cm_addr_d = cm_addr_q;
    cm_data_d = cm_data_q;
    cr_rd_req_d = 1'b0;
    cr_addr_d = cr_addr_q;
    cr_we_d = 1'b0;
    cr_wdata_d = cr_wdata_q;
    skip = 1'b0;
    unique case (state_q)
      STATE_IDLE: begin
        if (take) begin
          if (dec.kind == KIND_BRANCH) begin
            pc_load_d = 1'b1;
            pc_value_d = target_addr;  // see RQ1
            if (dec.target == TARGET_ROM) begin
              fetch_rom_d = 1'b1;  // see RQ3
            end else if (dec.target != TARGET_PC_REL) begin
              fetch_rom_d = 1'b0;
            end
            if (dec.save_reg) begin
              vpr_we_d = 1'b1;  // see RQ1
              vpr_idx_d = r_field;
              vpr_data_d = return_word(fetch_rom_q, pc_in);  // see RQ2
            end
            if (dec.save_slot) begin
              cm_we_d = 1'b1;  // see RQ6
              cm_addr_d = ADDR_W'(`SLOT_BASE_ADDR) + ADDR_W'(vp_num);  // see RQ7
              cm_data_d = return_word(fetch_rom_q, pc_in);  // see RQ8
            end
          end else if (dec.kind == KIND_NONE) begin
            instr_reject_d = 1'b1;
          end else begin
            // Flag work needs the byte first, so the unit stalls
            kind_d = dec.kind;
            vp_d = vp_num;
            pc_hold_d = pc_in;
            cr_rd_req_d = 1'b1;
            cr_addr_d = tn_field[CR_ADDR_W-1:0];
            state_d = STATE_CR_WAIT;
          end
        end
      end
      STATE_CR_WAIT: begin
        if (cr_rd_valid) begin
          skip = ((kind_q == KIND_TEST_ONE) && fop.bit_value)  // see RQ13
              || ((kind_q == KIND_TEST_ZERO) && !fop.bit_value);  // see RQ14
          cr_we_d = (kind_q == KIND_FLAG_SET) || (kind_q == KIND_FLAG_CLEAR);
          cr_wdata_d = fop.byte_out;  // see RQ10
          pc_load_d = 1'b1;
          pc_value_d = pc_hold_q + (skip ? ADDR_W'(`PC_STEP_SKIP) : ADDR_W'(`PC_STEP_NEXT));  // see RQ15
          state_d = STATE_IDLE;
        end
      end
    endcase
    instr_ready_d = (state_d == STATE_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= STATE_IDLE;
      kind_q <= KIND_NONE;
      vp_q <= '0;
      pc_hold_q <= '0;
      instr_ready_q <= 1'b0;
      instr_reject_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_value_q <= '0;
      fetch_rom_q <= `FETCH_ROM_RESET;
      vpr_we_q <= 1'b0;
      vpr_idx_q <= '0;
      vpr_data_q <= '0;
      cm_we_q <= 1'b0;
      cm_addr_q <= '0;
      cm_data_q <= '0;
      cr_rd_req_q <= 1'b0;
      cr_addr_q <= '0;
      cr_we_q <= 1'b0;
      cr_wdata_q <= '0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      vp_q <= vp_d;
      pc_hold_q <= pc_hold_d;
      instr_ready_q <= instr_ready_d;
      instr_reject_q <= instr_reject_d;
      pc_load_q <= pc_load_d;
      pc_value_q <= pc_value_d;
      fetch_rom_q <= fetch_rom_d;
      vpr_we_q <= vpr_we_d;
      vpr_idx_q <= vpr_idx_d;
      vpr_data_q <= vpr_data_d;
      cm_we_q <= cm_we_d;
      cm_addr_q <= cm_addr_d;
      cm_data_q <= cm_data_d;
      cr_rd_req_q <= cr_rd_req_d;
      cr_addr_q <= cr_addr_d;
      cr_we_q <= cr_we_d;
      cr_wdata_q <= cr_wdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [BYTE_W-1:0] rd_byte_seen;
  assign rd_byte_seen = cr_rd_data;

  sequence take_save_reg;
    take && dec.kind == KIND_BRANCH && dec.save_reg;
  endsequence

  sequence flag_read_done;
    state_q == STATE_CR_WAIT && cr_rd_valid;
  endsequence

  AST_SAVE_REG: assert property (take_save_reg |=> vpr_we_q && pc_load_q  // see RQ1
      && vpr_data_q[ADDR_W-1:0] == $past(pc_in) + ADDR_W'(`PC_STEP_NEXT)
      && vpr_idx_q == $past(r_field))
    else $error("return address not saved to work register");

  AST_SAVE_MSB: assert property (take_save_reg |=> vpr_data_q[DATA_W-1] == !$past(fetch_rom_q))  // see RQ2
    else $error("saved register MSB does not show fetch source");

  AST_ROM_TARGET: assert property (take && dec.kind == KIND_BRANCH && dec.target == TARGET_ROM  // see RQ3
      |=> pc_load_q && fetch_rom_q && pc_value_q == $past(tn_field))
    else $error("ROM branch did not select ROM fetch");

  AST_PC_REL: assert property (take && (opcode == `OP_BRANCH_PC_RELATIVE_A  // see RQ4
      || opcode == `OP_BRANCH_PC_RELATIVE_B)
      |=> pc_value_q == $past(pc_in + tn_field) && !vpr_we_q && !cm_we_q)
    else $error("PC-relative branch target wrong or a save occurred");

  AST_NO_SAVE: assert property (take && dec.kind == KIND_BRANCH && !dec.save_reg && !dec.save_slot  // see RQ5
      |=> pc_load_q && !vpr_we_q && !cm_we_q)
    else $error("plain branch wrote a save location");

  AST_SLOT_ADDR: assert property (take && opcode == `OP_BRANCH_ROM_STORE_SLOT  // see RQ7
      |=> cm_we_q && cm_addr_q == ADDR_W'(`SLOT_BASE_ADDR) + ADDR_W'($past(vp_num))
      && cm_data_q[ADDR_W-1:0] == $past(pc_in) + ADDR_W'(`PC_STEP_NEXT))
    else $error("store slot address or data wrong");

  AST_SLOT_MSB: assert property (take && opcode == `OP_BRANCH_ROM_STORE_SLOT  // see RQ8
      |=> cm_data_q[DATA_W-1] == !$past(fetch_rom_q) && fetch_rom_q)
    else $error("store slot MSB does not show fetch source");

  AST_FLAG_ONE_BIT: assert property (flag_read_done ##0 (kind_q == KIND_FLAG_SET || kind_q == KIND_FLAG_CLEAR)  // see RQ12
      |=> cr_we_q && ((cr_wdata_q ^ $past(rd_byte_seen)) & ~(BYTE_W'(1) << $past(vp_q))) == '0
      && cr_wdata_q[$past(vp_q)] == ($past(kind_q) == KIND_FLAG_SET))
    else $error("flag write touched the wrong bit");

  AST_TEST_SKIP: assert property (flag_read_done ##0 (kind_q == KIND_TEST_ONE || kind_q == KIND_TEST_ZERO)  // see RQ13
      |=> pc_load_q && !cr_we_q && pc_value_q == $past(pc_hold_q)
      + (($past(rd_byte_seen[vp_q]) == ($past(kind_q) == KIND_TEST_ONE))
      ? ADDR_W'(`PC_STEP_SKIP) : ADDR_W'(`PC_STEP_NEXT)))
    else $error("flag test advanced PC by the wrong amount");

  AST_FLAG_ISSUE: assert property (take && (dec.kind == KIND_FLAG_SET || dec.kind == KIND_TEST_ZERO)  // see RQ14
      |=> cr_rd_req_q && !instr_ready_q && cr_addr_q == $past(tn_field[CR_ADDR_W-1:0]))
    else $error("flag instruction did not request its byte");
endmodule

/* verif/cr_file_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Communication register file stand-in
// ----------------------------------------------------------------
// Answers byte reads after a settable delay. Between answers the data
// lines toggle every cycle, so a stale byte is never mistaken for a fresh one.
module cr_file_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Requests from the unit
  input wire logic rd_req,
  input wire logic [7:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  // Answer delay in cycles, 1 or more
  input wire logic [3:0] lat,
  // Read answer
  output logic rd_valid_q,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem [256];
  logic [7:0] addr_q;
  logic [3:0] cnt_q;
  logic busy_q;

  // Contents survive reset, as the shared file does
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end

  // A write lands on the edge that sees its strobe
  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[addr] <= wdata;
    end
  end

  // Read sequencer: one read outstanding at a time
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      rd_valid_q <= 1'b0;
      rd_data_q <= ~rd_data_q;
      if (rd_req === 1'b1) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
        addr_q <= addr;
      end else if (busy_q && cnt_q <= 4'h1) begin
        busy_q <= 1'b0;
        rd_valid_q <= 1'b1;
        rd_data_q <= mem[addr_q];
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

/* verif/tb_pp_branch_and_flag_unit.sv */
`timescale 1ns/10ps

module tb_pp_branch_and_flag_unit;
  typedef struct packed {
    logic [7:0] opc;
    logic [3:0] r;
    logic [15:0] tn;
    logic [15:0] pc;
    logic [15:0] base;
    logic [2:0] vp;
    logic [15:0] pcv;
  } row_t;
  typedef struct {
    logic rej, pcl, rom, vwe, cwe, crwe;
    logic [15:0] pcv, caddr;
    logic [3:0] vidx;
    logic [31:0] vdat, cdat;
    logic [7:0] crw;
  } resp_t;

  logic clk, arst_n, instr_valid, indirect, cr_rd_valid;
  logic [7:0] opcode, cr_rd_data, cr_addr_q, cr_wdata_q;
  logic [3:0] r_field, vpr_idx_q, lat;
  logic [15:0] tn_field, pc_in, base_in, pc_value_q, cm_addr_q;
  logic [2:0] vp_num;
  logic instr_ready_q, instr_reject_q, pc_load_q, fetch_rom_q, vpr_we_q, cm_we_q, cr_rd_req_q, cr_we_q;
  logic [31:0] vpr_data_q, cm_data_q;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic rom_now = 1'b1;
  logic [7:0] mirror [256];
  resp_t exp_q [$];
  logic [7:0] cra_q [$];
  row_t rows [24];

  pp_branch_and_flag_unit uut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .opcode(opcode),
    .r_field(r_field), .tn_field(tn_field), .indirect(indirect), .vp_num(vp_num), .pc_in(pc_in),
    .base_in(base_in), .instr_ready_q(instr_ready_q), .instr_reject_q(instr_reject_q), .pc_load_q(pc_load_q),
    .pc_value_q(pc_value_q), .fetch_rom_q(fetch_rom_q), .vpr_we_q(vpr_we_q), .vpr_idx_q(vpr_idx_q),
    .vpr_data_q(vpr_data_q), .cm_we_q(cm_we_q), .cm_addr_q(cm_addr_q), .cm_data_q(cm_data_q),
    .cr_rd_req_q(cr_rd_req_q), .cr_addr_q(cr_addr_q), .cr_rd_valid(cr_rd_valid), .cr_rd_data(cr_rd_data),
    .cr_we_q(cr_we_q), .cr_wdata_q(cr_wdata_q));

  cr_file_model partner (.clk(clk), .arst_n(arst_n), .rd_req(cr_rd_req_q), .addr(cr_addr_q), .we(cr_we_q),
    .wdata(cr_wdata_q), .lat(lat), .rd_valid_q(cr_rd_valid), .rd_data_q(cr_rd_data));

  // ----------------------------------------------------------------
  // Clock, timeout, comparison and verdict
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  // Far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scoreboard: every strobe cycle must match the oldest expectation
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    resp_t e;
    if (cr_rd_req_q === 1'b1) begin
      if (cra_q.size() > 0) check(cr_addr_q, cra_q.pop_front());
      else check(1'b1, 1'b0);
      check(instr_ready_q, 1'b0);
    end
    if ((pc_load_q | vpr_we_q | cm_we_q | cr_we_q | instr_reject_q) === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        e = exp_q.pop_front();
        check(instr_reject_q, e.rej);
        check(pc_load_q, e.pcl);
        if (e.pcl) check(pc_value_q, e.pcv);
        check(fetch_rom_q, e.rom);
        check(vpr_we_q, e.vwe);
        if (e.vwe) check(vpr_idx_q, e.vidx);
        if (e.vwe) check(vpr_data_q, e.vdat);
        check(cm_we_q, e.cwe);
        if (e.cwe) check(cm_addr_q, e.caddr);
        if (e.cwe) check(cm_data_q, e.cdat);
        check(cr_we_q, e.crwe);
        if (e.crwe) check(cr_wdata_q, e.crw);
      end
    end
  end

  // Queue the expected answer, then offer the instruction until taken
  task automatic op(input row_t w);
    resp_t e;
    logic [7:0] b;
    int n;
    e = '{default: '0};
    b = mirror[w.tn[7:0]];
    e.pcl = 1'b1;
    e.pcv = w.pcv;
    e.rom = rom_now;
    e.vidx = w.r;
    e.vdat = {~rom_now, 15'h0000, w.pc + 16'h0001};
    e.cdat = e.vdat;
    e.caddr = 16'h0020 + 16'(w.vp);
    case (w.opc)
      8'h12, 8'h52: begin
        e.rom = 1'b0;
        e.vwe = 1'b1;
      end
      8'h46: begin
        e.rom = 1'b1;
        e.vwe = 1'b1;
      end
      8'h42: e.rom = 1'b1;
      8'h02, 8'h32, 8'h4A, 8'h4E: e.rom = 1'b0;
      8'h5A, 8'h5E: e.rom = rom_now;
      8'h56: begin
        e.rom = 1'b1;
        e.cwe = 1'b1;
      end
      8'h86, 8'h82: begin
        e.crwe = 1'b1;
        e.crw = (w.opc == 8'h86) ? (b | (8'h01 << w.vp)) : (b & ~(8'h01 << w.vp));
        mirror[w.tn[7:0]] = e.crw;
        cra_q.push_back(w.tn[7:0]);
      end
      8'h8E, 8'h8A: cra_q.push_back(w.tn[7:0]);
      default: begin
        e.pcl = 1'b0;
        e.rej = 1'b1;
      end
    endcase
    rom_now = e.rom;
    exp_q.push_back(e);
    opcode <= w.opc;
    r_field <= w.r;
    tn_field <= w.tn;
    pc_in <= w.pc;
    base_in <= w.base;
    vp_num <= w.vp;
    indirect <= 1'b0;
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_ready_q !== 1'b1 && n < 40);
    if (n >= 40) check(1'b1, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {instr_valid, indirect, opcode, r_field, tn_field, pc_in, base_in, vp_num} = '0;
    lat = 4'h1;
    for (int i = 0; i < 256; i++) mirror[i] = 8'(i) ^ 8'h5A;
    rows = '{
      '{8'h12, 4'h3, 16'h0010, 16'h0100, 16'h1000, 3'h0, 16'h1010}, '{8'h52, 4'hF, 16'h2345, 16'h1010, 16'h0, 3'h1, 16'h2345},
      '{8'h5A, 4'h0, 16'h0020, 16'h2345, 16'h0, 3'h2, 16'h2365}, '{8'h5E, 4'h0, 16'hFFF0, 16'h2365, 16'h0, 3'h2, 16'h2355},
      '{8'h02, 4'h0, 16'h0004, 16'h2355, 16'h3000, 3'h0, 16'h3004}, '{8'h32, 4'h0, 16'h0008, 16'h3004, 16'h3000, 3'h0, 16'h3008},
      '{8'h4A, 4'h0, 16'h4000, 16'h3008, 16'h0, 3'h0, 16'h4000}, '{8'h4E, 4'h0, 16'h4444, 16'h4000, 16'h0, 3'h0, 16'h4444},
      '{8'h46, 4'h7, 16'h0600, 16'h4444, 16'h0, 3'h0, 16'h0600}, '{8'h42, 4'h0, 16'h0700, 16'h0600, 16'h0, 3'h0, 16'h0700},
      '{8'h5A, 4'h0, 16'h0010, 16'h0700, 16'h0, 3'h0, 16'h0710}, '{8'h56, 4'h0, 16'h0800, 16'hFFFF, 16'h0, 3'h7, 16'h0800},
      '{8'h46, 4'h0, 16'h0900, 16'h0800, 16'h0, 3'h0, 16'h0900}, '{8'h52, 4'h1, 16'h1234, 16'h0900, 16'h0, 3'h0, 16'h1234},
      '{8'h56, 4'h0, 16'h0050, 16'h1234, 16'h0, 3'h0, 16'h0050}, '{8'h86, 4'h0, 16'h125A, 16'h0050, 16'h0, 3'h3, 16'h0051},
      '{8'h8E, 4'h0, 16'h005A, 16'h0051, 16'h0, 3'h3, 16'h0053}, '{8'h8A, 4'h0, 16'h005A, 16'h0053, 16'h0, 3'h3, 16'h0054},
      '{8'h8A, 4'h0, 16'h005A, 16'h0054, 16'h0, 3'h2, 16'h0056}, '{8'h82, 4'h0, 16'h00A5, 16'h0056, 16'h0, 3'h5, 16'h0057},
      '{8'h8E, 4'h0, 16'h00A5, 16'h0057, 16'h0, 3'h5, 16'h0058}, '{8'h8E, 4'h0, 16'h00A5, 16'h0058, 16'h0, 3'h4, 16'h005A},
      '{8'h00, 4'h0, 16'h0000, 16'h005A, 16'h0, 3'h0, 16'h0000}, '{8'hAE, 4'h2, 16'h0000, 16'h005A, 16'h0, 3'h0, 16'h0000}};
    // Reset values while held, then the release latency
    repeat (12) @(posedge clk);
    check(fetch_rom_q, 1'b1);
    check(instr_ready_q, 1'b0);
    check(pc_load_q, 1'b0);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(instr_ready_q, 1'b0);
    @(posedge clk);
    #1 check(instr_ready_q, 1'b1);
    @(posedge clk);
    // Ordinary cases, offered back to back
    foreach (rows[i]) op(rows[i]);
    instr_valid <= 1'b0;
    // Slow answer: the clear and its test hold up a branch queued behind them
    lat <= 4'h6;
    repeat (2) @(posedge clk);
    op('{8'h82, 4'h0, 16'h005A, 16'h005A, 16'h0, 3'h3, 16'h005B});
    op('{8'h8A, 4'h0, 16'h005A, 16'h005B, 16'h0, 3'h3, 16'h005D});
    op('{8'h4A, 4'h0, 16'h0ABC, 16'h005D, 16'h0, 3'h0, 16'h0ABC});
    instr_valid <= 1'b0;
    repeat (12) @(posedge clk);
    check(exp_q.size(), 0);
    // Reset in mid-run takes hold at once
    arst_n <= 1'b0;
    #1 check(fetch_rom_q, 1'b1);
    check(instr_ready_q, 1'b0);
    @(posedge clk);
    arst_n <= 1'b1;
    rom_now = 1'b1;
    repeat (3) @(posedge clk);
    op('{8'h5E, 4'h0, 16'h0003, 16'h0100, 16'h0, 3'h0, 16'h0103});
    instr_valid <= 1'b0;
    repeat (5) @(posedge clk);
    check(exp_q.size(), 0);
    wrap_up();
  end
endmodule
